// [hw/period_timer_pkg.sv]
// Functional notes
// [RQ1] Eight-bit up-counting timer count register.
// [RQ2] Eight-bit limit register compared on increment.
// [RQ3] Count and limit are software read/write.
// [RQ4] Prescale select: 00 is 1, 01 is 4, 1x is 16.
// [RQ5] Postscale ratio equals field value plus one.
// [RQ6] Count equal to limit raises match condition.
// [RQ7] Run bit gates counting; stopped holds count.
// [RQ8] Unimplemented bits read zero; reset all zero.
// [RQ9] Flags set regardless of any enable bit.
// [RQ10] Software clears flag before enabling interrupt.
// [RQ11] Match flag bit 1 sticky until cleared.
// [RQ12] Conversion done flag bit 6 sticky.
// [RQ13] Capture/compare flag bit 2, unused in PWM.
// [RQ14] Wide timer overflow flag bit 0 sticky.
// [RQ15] Flag bits 7 and 5-3 read zero.
// [RQ16] Timer input is instruction clock, four periods.
// [RQ17] Count increments per tick, wraps after match.
// [RQ18] Flag set only on every Nth match.
// [RQ19] Count or control write clears scaler counts.
package period_timer_pkg;

	// ****************************************************************
	// Register map.
	// ****************************************************************
	// Two printed offsets are register indices, not byte addresses.
	// The bus sees each register at four times its index.
	localparam logic [7:0] FLAGS_INDEX   = 8'h0C;
	localparam logic [7:0] CONTROL_INDEX = 8'h12;
	localparam logic [7:0] FLAGS_ADDR   = {FLAGS_INDEX[5:0], 2'h0};
	localparam logic [7:0] CONTROL_ADDR = {CONTROL_INDEX[5:0], 2'h0};
	localparam logic [7:0] COUNT_ADDR   = 8'h20;
	localparam logic [7:0] LIMIT_ADDR   = 8'h24;
	localparam logic [7:0] ENABLE_ADDR  = 8'h28;
	localparam logic [7:0] CLEAR_ADDR   = 8'h2C;

	// ****************************************************************
	// Field positions and masks.
	// ****************************************************************
	localparam int WIDE_OVF_BIT  = 0;
	localparam int MATCH_BIT     = 1;
	localparam int CAPCMP_BIT    = 2;
	localparam int CONV_BIT      = 6;
	localparam logic [7:0] FLAGS_MASK   = 8'h47;
	localparam logic [7:0] CONTROL_MASK = 8'h7F;
	localparam logic [7:0] RESET_VALUE  = 8'h00;
	localparam int RUN_BIT       = 2;
	localparam int POST_LSB      = 3;

	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int OSC_PER_INSN  = 4;
	localparam logic [3:0] PRE_LAST_DIV1  = 4'h0;
	localparam logic [3:0] PRE_LAST_DIV4  = 4'h3;
	localparam logic [3:0] PRE_LAST_DIV16 = 4'hF;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register layout.
	typedef struct packed {
		logic       unused;
		logic [3:0] postscale_select;
		logic       period_timer_run;
		logic [1:0] prescale_select;
	} control_t;

	// Hardware event strobes.
	typedef struct packed {
		logic conversion_done;
		logic capture_compare;
		logic wide_timer_overflow;
	} events_t;

endpackage

// [hw/period_match_timer.sv]
`timescale 1ns/1ps
module period_match_timer
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire period_timer_pkg::events_t events_i,
	input  wire logic                     pwm_mode_i,
	input  wire logic [7:0]               s_awaddr_i,
	input  wire logic                     s_awvalid_i,
	output logic                          s_awready_o,
	input  wire logic [31:0]              s_wdata_i,
	input  wire logic [3:0]               s_wstrb_i,
	input  wire logic                     s_wvalid_i,
	output logic                          s_wready_o,
	output logic [1:0]                    s_bresp_o,
	output logic                          s_bvalid_o,
	input  wire logic                     s_bready_i,
	input  wire logic [7:0]               s_araddr_i,
	input  wire logic                     s_arvalid_i,
	output logic                          s_arready_o,
	output logic [31:0]                   s_rdata_o,
	output logic [1:0]                    s_rresp_o,
	output logic                          s_rvalid_o,
	input  wire logic                     s_rready_i,
	output logic                          irq_o
);

	// ****************************************************************
	// Registers and internal state.
	// ****************************************************************
	period_timer_pkg::control_t control;
	logic [7:0]                 count;
	logic [7:0]                 limit;
	logic [7:0]                 flags;
	logic [7:0]                 enable;
	logic [1:0]                 insn_phase;
	logic [3:0]                 pre_count;
	logic [3:0]                 post_count;
	logic                       aw_held;
	logic                       w_held;
	logic [7:0]                 aw_addr;
	logic [31:0]                w_data;
	logic [3:0]                 w_strb;
	logic                       wr_go;
	logic                       wr_count;
	logic                       wr_control;
	logic                       wr_lane0;
	logic                       tick;
	logic                       incr;
	logic                       match;
	logic                       post_hit;
	logic [3:0]                 pre_last;
	logic [2:0]                 ev_q1;
	logic [2:0]                 ev_q2;
	logic [2:0]                 ev_q3;
	logic [2:0]                 ev_rise;
	logic [1:0]                 pwm_q;
	logic [7:0]                 set_bits;
	logic [7:0]                 clr_bits;
	logic [7:0]                 rd_value;
	logic                       rd_known;

	// ****************************************************************
	// Write channel: address and data taken in either order.
	// ****************************************************************
	assign wr_go    = aw_held && w_held && !s_bvalid_o;
	assign wr_lane0 = wr_go && w_strb[0];
	assign wr_count   = wr_lane0 && aw_addr == period_timer_pkg::COUNT_ADDR;
	assign wr_control = wr_lane0
		&& aw_addr == period_timer_pkg::CONTROL_ADDR;

	// Captures address and data and raises the response after both.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_held     <= 1'b0;
			w_held      <= 1'b0;
			aw_addr     <= 8'h00;
			w_data      <= 32'h0000_0000;
			w_strb      <= 4'h0;
			s_awready_o <= 1'b0;
			s_wready_o  <= 1'b0;
			s_bvalid_o  <= 1'b0;
			s_bresp_o   <= 2'h0;
		end
		else
		begin
			s_awready_o <= !aw_held && !s_awready_o;
			s_wready_o  <= !w_held && !s_wready_o;
			if (s_awvalid_i && s_awready_o)
			begin
				aw_held     <= 1'b1;
				aw_addr     <= s_awaddr_i;
				s_awready_o <= 1'b0;
			end
			if (s_wvalid_i && s_wready_o)
			begin
				w_held     <= 1'b1;
				w_data     <= s_wdata_i;
				w_strb     <= s_wstrb_i;
				s_wready_o <= 1'b0;
			end
			if (wr_go)
			begin
				s_bvalid_o <= 1'b1;
				case (aw_addr)
					period_timer_pkg::FLAGS_ADDR,
					period_timer_pkg::CONTROL_ADDR,
					period_timer_pkg::COUNT_ADDR,
					period_timer_pkg::LIMIT_ADDR,
					period_timer_pkg::ENABLE_ADDR,
					period_timer_pkg::CLEAR_ADDR:
						s_bresp_o <= period_timer_pkg::RESP_OKAY;
					default:
						s_bresp_o <= period_timer_pkg::RESP_SLVERR;
				endcase
			end
			if (s_bvalid_o && s_bready_i)
			begin
				s_bvalid_o <= 1'b0;
				aw_held    <= 1'b0;
				w_held     <= 1'b0;
			end
		end
	end

	// Software-written configuration registers.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			control <= period_timer_pkg::RESET_VALUE; // RQ8
			limit   <= period_timer_pkg::RESET_VALUE;
			enable  <= period_timer_pkg::RESET_VALUE;
		end
		else if (wr_lane0)
		begin
			if (wr_control)
				control <= w_data[7:0] & period_timer_pkg::CONTROL_MASK; // RQ8
			if (aw_addr == period_timer_pkg::LIMIT_ADDR)
				limit <= w_data[7:0]; // RQ3
			if (aw_addr == period_timer_pkg::ENABLE_ADDR)
				enable <= w_data[7:0] & period_timer_pkg::FLAGS_MASK;
		end
	end

	// ****************************************************************
	// Prescaler and counter.
	// ****************************************************************

	// Instruction clock strobe: one tick every four input clocks.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			insn_phase <= 2'h0;
		else
			insn_phase <= insn_phase + 2'h1; // RQ16
	end

	// Prescaler terminal count by select code.
	always_comb
	begin
		if (control.prescale_select[1])
			pre_last = period_timer_pkg::PRE_LAST_DIV16; // RQ4
		else if (control.prescale_select[0])
			pre_last = period_timer_pkg::PRE_LAST_DIV4; // RQ4
		else
			pre_last = period_timer_pkg::PRE_LAST_DIV1; // RQ4
	end

	assign tick  = control.period_timer_run
		&& insn_phase == 2'(period_timer_pkg::OSC_PER_INSN - 1); // RQ7
	assign incr  = tick && pre_count == pre_last;
	assign match = incr && count == limit; // RQ2 RQ6
	assign post_hit = match && post_count == control.postscale_select;

	// Prescale divider; cleared by a count or control write.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			pre_count <= 4'h0;
		else if (wr_count || wr_control)
			pre_count <= 4'h0; // RQ19
		else if (incr)
			pre_count <= 4'h0;
		else if (tick)
			pre_count <= pre_count + 4'h1;
	end

	// The count: software write wins, else increment or wrap.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count <= 8'h00;
		else if (wr_count)
			count <= w_data[7:0]; // RQ3
		else if (match)
			count <= 8'h00; // RQ17
		else if (incr)
			count <= count + 8'h01; // RQ1 RQ17
	end

	// Postscaler counts matches.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			post_count <= 4'h0;
		else if (wr_count || wr_control)
			post_count <= 4'h0; // RQ19
		else if (post_hit)
			post_count <= 4'h0; // RQ5 RQ18
		else if (match)
			post_count <= post_count + 4'h1; // RQ18
	end

	// ****************************************************************
	// Event inputs and flags.
	// ****************************************************************

	// Two-stage synchroniser plus an edge register for each event.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ev_q1 <= 3'h0;
			ev_q2 <= 3'h0;
			ev_q3 <= 3'h0;
			pwm_q <= 2'h0;
		end
		else
		begin
			ev_q1 <= events_i;
			ev_q2 <= ev_q1;
			ev_q3 <= ev_q2;
			pwm_q <= {pwm_q[0], pwm_mode_i};
		end
	end

	assign ev_rise = ev_q2 & ~ev_q3;

	// Set terms beat clear terms in the same cycle.
	always_comb
	begin
		set_bits = 8'h00;
		set_bits[period_timer_pkg::MATCH_BIT]    = post_hit; // RQ11
		set_bits[period_timer_pkg::CONV_BIT]     = ev_rise[2]; // RQ12
		set_bits[period_timer_pkg::CAPCMP_BIT]   = ev_rise[1] && !pwm_q[1]; // RQ13
		set_bits[period_timer_pkg::WIDE_OVF_BIT] = ev_rise[0]; // RQ14
		clr_bits = 8'h00;
		if (wr_lane0 && aw_addr == period_timer_pkg::CLEAR_ADDR)
			clr_bits = w_data[7:0];
		else if (wr_lane0 && aw_addr == period_timer_pkg::FLAGS_ADDR)
			clr_bits = ~w_data[7:0];
	end

	// Sticky flags, set regardless of enables.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			flags <= period_timer_pkg::RESET_VALUE;
		else
			flags <= ((flags & ~clr_bits) | set_bits)
				& period_timer_pkg::FLAGS_MASK; // RQ9 RQ15
	end

	// Level interrupt from enabled flags.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= |(flags & enable);
	end

	// ****************************************************************
	// Read channel.
	// ****************************************************************

	// Read data decode.
	always_comb
	begin
		rd_known = 1'b1;
		case (s_araddr_i)
			period_timer_pkg::FLAGS_ADDR:   rd_value = flags; // RQ15
			period_timer_pkg::CONTROL_ADDR: rd_value = control; // RQ8
			period_timer_pkg::COUNT_ADDR:   rd_value = count; // RQ3
			period_timer_pkg::LIMIT_ADDR:   rd_value = limit; // RQ3
			period_timer_pkg::ENABLE_ADDR:  rd_value = enable;
			period_timer_pkg::CLEAR_ADDR:   rd_value = 8'h00;
			default:
			begin
				rd_value = 8'h00;
				rd_known = 1'b0;
			end
		endcase
	end

	// Takes one read and answers it on the next cycle.
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_arready_o <= 1'b0;
			s_rvalid_o  <= 1'b0;
			s_rdata_o   <= 32'h0000_0000;
			s_rresp_o   <= 2'h0;
		end
		else
		begin
			s_arready_o <= !s_rvalid_o && !s_arready_o;
			if (s_arvalid_i && s_arready_o)
			begin
				s_arready_o <= 1'b0;
				s_rvalid_o  <= 1'b1;
				s_rdata_o   <= {24'h000000, rd_value};
				s_rresp_o   <= rd_known ? period_timer_pkg::RESP_OKAY
					: period_timer_pkg::RESP_SLVERR;
			end
			else if (s_rvalid_o && s_rready_i)
				s_rvalid_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	period_wrap_a: assert property ( // RQ17
		@(posedge clk_i) disable iff (rst_i)
		match && !wr_count |=> count == 8'h00)
		else $error("count did not wrap after match");
	stop_holds_a: assert property ( // RQ7
		@(posedge clk_i) disable iff (rst_i)
		!control.period_timer_run && !wr_count |=> $stable(count))
		else $error("count moved while stopped");
	match_sticky_a: assert property ( // RQ11
		@(posedge clk_i) disable iff (rst_i)
		flags[1] && clr_bits[1] == 1'b0 |=> flags[1])
		else $error("match flag dropped without clear");
	flag_set_a: assert property ( // RQ9
		@(posedge clk_i) disable iff (rst_i)
		post_hit |=> flags[1])
		else $error("match flag not set");
	unused_zero_a: assert property ( // RQ15
		@(posedge clk_i) disable iff (rst_i)
		flags[7] == 1'b0 && flags[5:3] == 3'h0)
		else $error("unimplemented flag bit set");
	ctrl_top_a: assert property ( // RQ8
		@(posedge clk_i) disable iff (rst_i)
		control[7] == 1'b0)
		else $error("control bit 7 set");
	pre_one_a: assert property ( // RQ4
		@(posedge clk_i) disable iff (rst_i)
		tick && control.prescale_select == 2'h0 |-> incr)
		else $error("divide by one missed tick");
	scaler_clear_a: assert property ( // RQ19
		@(posedge clk_i) disable iff (rst_i)
		wr_control |=> pre_count == 4'h0 && post_count == 4'h0)
		else $error("scaler not cleared");
	insn_rate_a: assert property ( // RQ16
		@(posedge clk_i) disable iff (rst_i)
		tick |=> !tick [*3])
		else $error("tick faster than instruction clock");
	post_bound_a: assert property ( // RQ5 RQ18
		@(posedge clk_i) disable iff (rst_i)
		match && !wr_count && !wr_control
		&& post_count != control.postscale_select
		|=> post_count == $past(post_count) + 4'h1)
		else $error("postscaler did not advance");
	conv_flag_a: assert property ( // RQ12
		@(posedge clk_i) disable iff (rst_i)
		ev_rise[2] |=> flags[6])
		else $error("conversion flag not set");
	ovf_flag_a: assert property ( // RQ14
		@(posedge clk_i) disable iff (rst_i)
		ev_rise[0] |=> flags[0])
		else $error("overflow flag not set");
	capcmp_flag_a: assert property ( // RQ13
		@(posedge clk_i) disable iff (rst_i)
		ev_rise[1] && !pwm_q[1] |=> flags[2])
		else $error("capture flag not set");

endmodule

// [testbench/test_period_match_timer.sv]
`timescale 1ns/1ps
module test_period_match_timer;
	// ****************************************************************
	// Bench signals, reference flags and counters.
	// ****************************************************************
	logic                      clk_i = 1'b0;
	logic                      rst_i;
	logic                      pwm_mode_i;
	period_timer_pkg::events_t events_i;
	logic [7:0]                awaddr;
	logic [7:0]                araddr;
	logic [31:0]               wdata;
	logic [31:0]               rdata;
	logic [3:0]                wstrb;
	logic [1:0]                bresp;
	logic [1:0]                rresp;
	logic [1:0]                resp;
	logic [31:0]               rd;
	logic                      awvalid, wvalid, bready, arvalid, rready;
	logic                      awready, wready, bvalid, arready, rvalid;
	logic                      irq;
	int                        fail_count, num_checks, seed, flags_m;
	int                        n, t, pre, s, v;

	period_match_timer dut
	(
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.events_i    (events_i),
		.pwm_mode_i  (pwm_mode_i),
		.s_awaddr_i  (awaddr),
		.s_awvalid_i (awvalid),
		.s_awready_o (awready),
		.s_wdata_i   (wdata),
		.s_wstrb_i   (wstrb),
		.s_wvalid_i  (wvalid),
		.s_wready_o  (wready),
		.s_bresp_o   (bresp),
		.s_bvalid_o  (bvalid),
		.s_bready_i  (bready),
		.s_araddr_i  (araddr),
		.s_arvalid_i (arvalid),
		.s_arready_o (arready),
		.s_rdata_o   (rdata),
		.s_rresp_o   (rresp),
		.s_rvalid_o  (rvalid),
		.s_rready_i  (rready),
		.irq_o       (irq)
	);

	// The clock toggles every half period of 20 ns.
	always #20 clk_i = ~clk_i;

	// Prints the counts and the verdict, then ends the run.
	task stop_test;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Compares one seen value with its expected value.
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// A wait that ran out of cycles ends the run as a failure.
	task give_up(input logic done);
		if (!done)
		begin
			fail_count++;
			stop_test();
		end
	endtask

	// One write: address and data offered together, each released once taken.
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bready && bvalid)
			begin
				resp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		give_up(done);
	endtask

	// One read: the address is held until taken, data kept at the answer.
	task rdr(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid)
			begin
				rd = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		give_up(done);
	endtask

	// Reads a register and compares it with the reference value.
	task rchk(input string name, input logic [7:0] a, input int exp);
		rdr(a);
		check(name, rd, exp);
	endtask

	// Raises one event line for a few cycles, then lets it settle.
	task ev(input int b);
		@(posedge clk_i);
		events_i[b] <= 1'b1;
		repeat (4) @(posedge clk_i);
		events_i[b] <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask

	// Main sequence: reset, register access, events, timer timing.
	initial
	begin
		seed = 42;
		fail_count = 0;
		num_checks = 0;
		flags_m = 0;
		rst_i = 1'b1;
		pwm_mode_i = 1'b0;
		events_i = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rchk("flags", period_timer_pkg::FLAGS_ADDR, 0);
		rchk("control", period_timer_pkg::CONTROL_ADDR, 0);
		rchk("count", period_timer_pkg::COUNT_ADDR, 0);
		rchk("limit", period_timer_pkg::LIMIT_ADDR, 0);
		wr(8'h40, 32'h000000FF);
		check("unmapped wr", resp, period_timer_pkg::RESP_SLVERR);
		rchk("unmapped rd", 8'h40, 0);
		check("unmapped rr", resp, period_timer_pkg::RESP_SLVERR);
		for (int i = 0; i < 4; i++)
		begin
			v = $random(seed);
			wr(period_timer_pkg::COUNT_ADDR, v);
			check("write resp", resp, period_timer_pkg::RESP_OKAY);
			wr(period_timer_pkg::LIMIT_ADDR, v >> 8);
			rchk("count rw", period_timer_pkg::COUNT_ADDR, v & 255);
			rchk("limit rw", period_timer_pkg::LIMIT_ADDR, (v >> 8) & 255);
		end
		wr(period_timer_pkg::CONTROL_ADDR, 32'hFFFFFFFB);
		rchk("control bits", period_timer_pkg::CONTROL_ADDR, 8'h7B);
		wr(period_timer_pkg::ENABLE_ADDR, 0);
		pwm_mode_i <= 1'b1;
		ev(1);
		rchk("pwm capture", period_timer_pkg::FLAGS_ADDR, 0);
		pwm_mode_i <= 1'b0;
		for (int b = 0; b < 3; b++)
		begin
			ev(b);
			flags_m = flags_m | (b == 0 ? 1 : b == 1 ? 4 : 64);
			rchk("event flag", period_timer_pkg::FLAGS_ADDR, flags_m);
		end
		wr(period_timer_pkg::FLAGS_ADDR, 32'h000000FF);
		rchk("flags keep", period_timer_pkg::FLAGS_ADDR, flags_m);
		check("irq masked", irq, 1'b0);
		wr(period_timer_pkg::ENABLE_ADDR, 8'h47);
		repeat (3) @(posedge clk_i);
		check("irq raised", irq, 1'b1);
		wr(period_timer_pkg::FLAGS_ADDR, 32'h000000FE);
		flags_m = flags_m & 8'hFE;
		rchk("flag zero", period_timer_pkg::FLAGS_ADDR, flags_m);
		wr(period_timer_pkg::CLEAR_ADDR, 8'h44);
		rchk("flags clear", period_timer_pkg::FLAGS_ADDR, 0);
		rchk("clear reads", period_timer_pkg::CLEAR_ADDR, 0);
		repeat (3) @(posedge clk_i);
		check("irq dropped", irq, 1'b0);
		wr(period_timer_pkg::ENABLE_ADDR, 2);
		wr(period_timer_pkg::LIMIT_ADDR, 3);
		for (int p = 0; p < 4; p++)
		begin
			s = p * 5;
			pre = (p == 0) ? 1 : (p == 1) ? 4 : 16;
			t = (s + 1) * 4 * pre * 4;
			wr(period_timer_pkg::COUNT_ADDR, 0);
			wr(period_timer_pkg::CLEAR_ADDR, 2);
			wr(period_timer_pkg::CONTROL_ADDR, (s << 3) | 4 | p);
			n = 0;
			while (irq !== 1'b1 && n < t + 40)
			begin
				@(posedge clk_i);
				n++;
			end
			check("match time", n >= t - 6 && n <= t + 8, 1);
			rchk("match flag", period_timer_pkg::FLAGS_ADDR, 2);
			wr(period_timer_pkg::CONTROL_ADDR, (s << 3) | p);
			rchk("control", period_timer_pkg::CONTROL_ADDR, (s << 3) | p);
			rdr(period_timer_pkg::COUNT_ADDR);
			v = rd;
			check("count wrap", v <= 3, 1);
			repeat (40) @(posedge clk_i);
			rchk("count held", period_timer_pkg::COUNT_ADDR, v);
			rchk("flag sticky", period_timer_pkg::FLAGS_ADDR, 2);
		end
		wr(period_timer_pkg::CONTROL_ADDR, 4);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rchk("control rst", period_timer_pkg::CONTROL_ADDR, 0);
		rchk("flags rst", period_timer_pkg::FLAGS_ADDR, 0);
		stop_test();
	end
endmodule
